// File: rtl/ppm_regs.svh
// register offsets, fields, reset values and function codes of the pulse monitor
`ifndef PPM_REGS_SVH
`define PPM_REGS_SVH
`define PPM_OFS_CTRL 8'h00
`define PPM_OFS_DIV 8'h04
`define PPM_OFS_GNUM 8'h08
`define PPM_OFS_GDEN 8'h0c
`define PPM_OFS_INPOS 8'h10
`define PPM_OFS_DEVLIM 8'h14
`define PPM_OFS_ROUGH 8'h18
`define PPM_OFS_DETLO 8'h1c
`define PPM_OFS_DETHI 8'h20
`define PPM_OFS_DETSIDE 8'h24
`define PPM_OFS_DETHYS 8'h28
`define PPM_OFS_INFUNC 8'h2c
`define PPM_OFS_OUTFUNC 8'h40
`define PPM_OFS_CUMMON 8'h60
`define PPM_OFS_CUMOVF 8'h64
`define PPM_OFS_CUMCNT 8'h68
`define PPM_OFS_STATUS 8'h6c
`define PPM_OFS_DROOP 8'h70
`define PPM_CTRL_CLRMODE 0
`define PPM_CTRL_STORE 1
`define PPM_ST_INPOS 0
`define PPM_ST_BUSY 1
`define PPM_ST_TRAVEL 2
`define PPM_ST_ROUGH 3
`define PPM_ST_DETECT 4
`define PPM_ST_FAULT 5
`define PPM_RST_GEAR 15'h0001
`define PPM_RST_DIV 16'h0001
`define PPM_RST_INPOS 15'h0064
`define PPM_RST_DEVLIM 19'h09c40
`define PPM_DEV_OFF 19'h0270f
`define PPM_MON_MAX 16'sh7fff
`define PPM_MON_MIN 16'sh8001
`define PPM_OVF_WEIGHT 32'sh00008000
`define PPM_DET_SCALE 14'h2710
`define PPM_GEAR_LIM 10'h384
`define PPM_FN_CLEAR 8'h34
`define PPM_FN_INPOS 8'h24
`define PPM_FN_INPOS_N 8'h88
`define PPM_FN_TRAVEL 8'h26
`define PPM_FN_TRAVEL_N 8'h8a
`define PPM_FN_DETECT 8'h3c
`define PPM_FN_DETECT_N 8'ha0
`define PPM_FN_BUSY 8'h3d
`define PPM_FN_BUSY_N 8'ha1
`define PPM_FN_ROUGH 8'h3e
`define PPM_FN_ROUGH_N 8'ha2
`endif

// File: rtl/ppm_pkg.sv
// types shared by the position pulse monitor
package ppm_pkg;
  typedef logic signed [31:0] ppm_pos_t;
  typedef enum logic [1:0] {PPM_SIDE_BOTH, PPM_SIDE_PLUS, PPM_SIDE_MINUS} ppm_side_t;
endpackage

// File: rtl/ppm_gear_scaler.sv
// step-rate scaler: position advances by mul/div per input step
`timescale 1ns/100ps
module ppm_gear_scaler #(
  parameter int RAT_W = 15
) (
  input wire logic core_clk_i, // clock
  input wire logic arst_n_i, // async reset
  input wire logic clr_i, // sync clear
  input wire logic step_i, // one input step
  input wire logic dir_i, // 1 forward
  input wire logic [RAT_W-1:0] mul_i, // ratio numerator
  input wire logic [RAT_W-1:0] div_i, // ratio denominator
  output ppm_pkg::ppm_pos_t pos_o // scaled position
);
  import ppm_pkg::*;
  if (RAT_W < 2 || RAT_W > 24) begin : g_bad_width
    $error("ppm_gear_scaler: RAT_W out of range");
  end
  // one output step per cycle: steps must come slower than ratio cycles
  logic signed [RAT_W+1:0] rem_reg;
  logic signed [RAT_W+1:0] rem_next;
  ppm_pos_t pos_reg;
  wire signed [RAT_W+1:0] mul_s = {2'b00, mul_i};
  wire signed [RAT_W+1:0] div_s = {2'b00, div_i};
  wire signed [RAT_W+1:0] in_term = step_i ? (dir_i ? mul_s : -mul_s) : '0;
  wire go_up = rem_reg >= div_s;
  wire go_dn = rem_reg <= -div_s;
  wire signed [RAT_W+1:0] out_term = go_up ? div_s : (go_dn ? -div_s : '0);
  assign rem_next = rem_reg + in_term - out_term;
  assign pos_o = pos_reg;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rem_reg <= '0;
      pos_reg <= '0;
    end else if (clr_i) begin
      rem_reg <= '0;
      pos_reg <= '0;
    end else begin
      rem_reg <= rem_next;
      if (go_up) begin
        pos_reg <= pos_reg + 32'sd1;
      end else if (go_dn) begin
        pos_reg <= pos_reg - 32'sd1;
      end
    end
  end
endmodule

// File: rtl/ppm_top.sv
// position pulse monitor: cumulative counter, gear, droop and flags
`timescale 1ns/100ps
`include "ppm_regs.svh"
// Overview of operation
// R1: cumulative count = division factor times (overflow times 32768 plus monitor)
// R2: encoder feedback counts every quadrature edge, four per line
// R3: clear mode 0 clears monitor and overflow on clear input rising edge
// R4: clear mode 1 holds monitor and overflow at zero while clear input high
// R5: clear input is taken only from terminals whose function code is 52
// R6: storage 0: no save at power loss, counters cleared on drive reset
// R7: storage 1: save at power loss, keep on reset, restore if option fitted
// R8: no save when power is lost during a drive reset
// R9: never save when the encoder option is absent
// R10: gear numerator and denominator 1 to 32767, reset 1, scale command pulses
// R11: gear ratio clamped to 1/900 .. 900
// R12: in-position when droop magnitude at or below width, default 100
// R13: droop = post-gear command minus post-gear feedback position
// R14: droop reaching deviation limit raises fault and shuts output, default 40000
// R15: deviation limit 9999 disables the fault
// R16: command-active flag on terminal codes 61 positive, 161 negative
// R17: in-position flag on terminal codes 36 positive, 136 negative
// R18: rough-match range 0 to 32767, default 0
// R19: detect value as low and high decimal halves, each 0 to 9999; the 14-bit registers take up to 16383 without a check
// R20: detect side 0 both, 1 plus only, 2 minus only
// R21: hysteresis width keeps the detect flag from chattering
// R22: detect when pre-gear position exceeds high*10000+low
// R23: rough match when remaining distance at or below range
// R24: travel complete = in-position and not command-active
// R25: monitor wraps past 32767, overflow counts signed with direction
// R26: compare droop magnitude; fault at or above limit
module ppm_top #(
  parameter int NUM_IN = 2,
  parameter int NUM_OUT = 4
) (
  input wire logic core_clk_i, // 25 MHz clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wr_data_i, // write data
  input wire logic wr_en_i, // write strobe
  input wire logic rd_en_i, // read strobe
  output logic [31:0] rd_data_o, // read data, cycle after strobe
  input wire logic enc_a_i, // encoder phase a pin
  input wire logic enc_b_i, // encoder phase b pin
  input wire logic [NUM_IN-1:0] term_in_i, // input terminal pins
  input wire logic cmd_step_i, // command pulse, one cycle
  input wire logic cmd_dir_i, // command direction, 1 forward
  input wire ppm_pkg::ppm_pos_t target_pos_i, // pre-gear target position
  input wire logic pos_cmd_busy_i, // position command running
  input wire logic drive_reset_i, // drive reset in progress pin
  input wire logic power_fail_i, // main power lost pin
  input wire logic power_up_i, // main power up pin
  input wire logic enc_option_i, // encoder option fitted pin
  input wire logic [15:0] nv_mon_i, // stored monitor value
  input wire logic [15:0] nv_ovf_i, // stored overflow count
  output logic [NUM_OUT-1:0] term_out_o, // output terminals
  output logic excessive_deviation_fault_o, // fault, output shut off
  output logic nv_save_o, // save pulse to memory
  output logic [15:0] nv_mon_o, // monitor value to save
  output logic [15:0] nv_ovf_o // overflow count to save
);
  import ppm_pkg::*;
  if (NUM_IN < 1 || NUM_IN > 4 || NUM_OUT < 1 || NUM_OUT > 8) begin : g_bad_count
    $error("ppm_top: terminal count out of range");
  end
  localparam int SW = NUM_IN + 6;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] sync3_reg;
  wire [SW-1:0] pin_raw = {enc_a_i, enc_b_i, drive_reset_i, power_fail_i,
                           power_up_i, enc_option_i, term_in_i};
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  wire enc_a = sync2_reg[SW-1];
  wire enc_b = sync2_reg[SW-2];
  wire enc_a_d = sync3_reg[SW-1];
  wire enc_b_d = sync3_reg[SW-2];
  wire drive_rst = sync2_reg[NUM_IN+3];
  wire pf_rise = sync2_reg[NUM_IN+2] & ~sync3_reg[NUM_IN+2];
  wire pu_rise = sync2_reg[NUM_IN+1] & ~sync3_reg[NUM_IN+1];
  wire option = sync2_reg[NUM_IN];
  wire [NUM_IN-1:0] term_in = sync2_reg[NUM_IN-1:0];

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic clr_mode_reg;
  logic store_reg;
  logic [15:0] div_reg;
  logic [14:0] gnum_reg;
  logic [14:0] gden_reg;
  logic [14:0] inpos_reg;
  logic [18:0] devlim_reg;
  logic [14:0] rough_reg;
  logic [13:0] detlo_reg;
  logic [13:0] dethi_reg;
  logic [1:0] side_reg;
  logic [14:0] hyst_reg;
  logic [7:0] in_func_reg [NUM_IN];
  logic [7:0] out_func_reg [NUM_OUT];
  wire wr_hit_ctrl = wr_en_i && addr_i == `PPM_OFS_CTRL;
  wire wr_hit_div = wr_en_i && addr_i == `PPM_OFS_DIV;
  wire wr_hit_gnum = wr_en_i && addr_i == `PPM_OFS_GNUM;
  wire wr_hit_gden = wr_en_i && addr_i == `PPM_OFS_GDEN;
  wire wr_hit_inpos = wr_en_i && addr_i == `PPM_OFS_INPOS;
  wire wr_hit_devlim = wr_en_i && addr_i == `PPM_OFS_DEVLIM;
  wire wr_hit_rough = wr_en_i && addr_i == `PPM_OFS_ROUGH;
  wire wr_hit_detlo = wr_en_i && addr_i == `PPM_OFS_DETLO;
  wire wr_hit_dethi = wr_en_i && addr_i == `PPM_OFS_DETHI;
  wire wr_hit_side = wr_en_i && addr_i == `PPM_OFS_DETSIDE;
  wire wr_hit_hyst = wr_en_i && addr_i == `PPM_OFS_DETHYS;
  // zero is outside the gear range; store it as one so the ratio stays defined
  wire [14:0] gear_wr = (wr_data_i[14:0] == 15'h0000) ? 15'h0001 : wr_data_i[14:0]; // R10
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_mode_reg <= 1'b0;
      store_reg <= 1'b0;
      div_reg <= `PPM_RST_DIV;
      gnum_reg <= `PPM_RST_GEAR; // R10
      gden_reg <= `PPM_RST_GEAR;
      inpos_reg <= `PPM_RST_INPOS; // R12
      devlim_reg <= `PPM_RST_DEVLIM; // R14
      rough_reg <= '0; // R18
      detlo_reg <= '0; // R19
      dethi_reg <= '0;
      side_reg <= PPM_SIDE_BOTH;
      hyst_reg <= '0;
    end else begin
      if (wr_hit_ctrl) begin
        clr_mode_reg <= wr_data_i[`PPM_CTRL_CLRMODE];
        store_reg <= wr_data_i[`PPM_CTRL_STORE];
      end
      if (wr_hit_div) div_reg <= wr_data_i[15:0];
      if (wr_hit_gnum) gnum_reg <= gear_wr;
      if (wr_hit_gden) gden_reg <= gear_wr;
      if (wr_hit_inpos) inpos_reg <= wr_data_i[14:0];
      if (wr_hit_devlim) devlim_reg <= wr_data_i[18:0];
      if (wr_hit_rough) rough_reg <= wr_data_i[14:0];
      if (wr_hit_detlo) detlo_reg <= wr_data_i[13:0];
      if (wr_hit_dethi) dethi_reg <= wr_data_i[13:0];
      if (wr_hit_side) side_reg <= wr_data_i[1:0];
      if (wr_hit_hyst) hyst_reg <= wr_data_i[14:0];
    end
  end

  // ------------------------------------------------------------
  // terminal function selection and input clear
  // ------------------------------------------------------------
  logic [NUM_IN-1:0] clr_sel;
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    wire hit = wr_en_i && addr_i == 8'(`PPM_OFS_INFUNC + 4 * i);
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        in_func_reg[i] <= '0;
      end else if (hit) begin
        in_func_reg[i] <= wr_data_i[7:0];
      end
    end
    assign clr_sel[i] = term_in[i] && in_func_reg[i] == `PPM_FN_CLEAR; // R5
  end
  logic clr_lvl_d_reg;
  wire clr_lvl = |clr_sel;
  wire clr_edge = clr_lvl & ~clr_lvl_d_reg;
  wire cum_clear = clr_mode_reg ? clr_lvl : clr_edge; // R3 R4
  wire rst_clear = drive_rst & ~store_reg; // R6 R7

  // ------------------------------------------------------------
  // quadrature decode and cumulative counter
  // ------------------------------------------------------------
  wire enc_step = enc_a ^ enc_a_d ^ enc_b ^ enc_b_d; // R2
  wire enc_fwd = enc_a_d ^ enc_b;
  logic signed [15:0] mon_reg;
  logic signed [15:0] ovf_reg;
  logic signed [15:0] mon_next;
  logic signed [15:0] ovf_next;
  wire restore = pu_rise & store_reg & option; // R7
  always_comb begin
    mon_next = mon_reg;
    ovf_next = ovf_reg;
    if (cum_clear || rst_clear) begin
      mon_next = '0;
      ovf_next = '0;
    end else if (restore) begin
      mon_next = nv_mon_i;
      ovf_next = nv_ovf_i;
    end else if (enc_step && enc_fwd) begin
      if (mon_reg == `PPM_MON_MAX) begin // R25
        mon_next = '0;
        ovf_next = ovf_reg + 16'sd1;
      end else begin
        mon_next = mon_reg + 16'sd1;
      end
    end else if (enc_step) begin
      if (mon_reg == `PPM_MON_MIN) begin // R25
        mon_next = '0;
        ovf_next = ovf_reg - 16'sd1;
      end else begin
        mon_next = mon_reg - 16'sd1;
      end
    end
  end
  // save only on a clean power loss with storage on and option fitted
  wire save_now = pf_rise & store_reg & option & ~drive_rst; // R7 R8 R9
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_lvl_d_reg <= 1'b0;
      mon_reg <= '0;
      ovf_reg <= '0;
      nv_save_o <= 1'b0;
      nv_mon_o <= '0;
      nv_ovf_o <= '0;
    end else begin
      clr_lvl_d_reg <= clr_lvl;
      mon_reg <= mon_next;
      ovf_reg <= ovf_next;
      nv_save_o <= save_now;
      if (save_now) begin
        nv_mon_o <= mon_reg;
        nv_ovf_o <= ovf_reg;
      end
    end
  end
  wire signed [31:0] cum_base = 32'(ovf_reg) * `PPM_OVF_WEIGHT + 32'(mon_reg);
  wire signed [31:0] cum_cnt = 32'(cum_base * $signed({16'h0000, div_reg})); // R1

  // ------------------------------------------------------------
  // electronic gear and positions
  // ------------------------------------------------------------
  wire [24:0] num_x = 25'(gnum_reg) * 25'(`PPM_GEAR_LIM);
  wire [24:0] den_x = 25'(gden_reg) * 25'(`PPM_GEAR_LIM);
  wire ratio_low = num_x < 25'(gden_reg);
  wire ratio_high = 25'(gnum_reg) > den_x;
  wire [14:0] mul_eff = ratio_low ? 15'h0001 :
                        (ratio_high ? 15'(`PPM_GEAR_LIM) : gnum_reg); // R11
  wire [14:0] div_eff = ratio_low ? 15'(`PPM_GEAR_LIM) :
                        (ratio_high ? 15'h0001 : gden_reg); // R11
  ppm_pos_t cmd_post;
  ppm_pos_t fb_pre;
  ppm_pos_t cmd_pre_reg;
  ppm_pos_t fb_post_reg;
  ppm_gear_scaler #(.RAT_W(15)) u_cmd_gear (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(drive_rst),
    .step_i(cmd_step_i),
    .dir_i(cmd_dir_i),
    .mul_i(mul_eff), // R10
    .div_i(div_eff),
    .pos_o(cmd_post)
  );
  // feedback back to command units for the pre-gear current position
  ppm_gear_scaler #(.RAT_W(15)) u_fb_gear (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(drive_rst),
    .step_i(enc_step),
    .dir_i(enc_fwd),
    .mul_i(div_eff),
    .div_i(mul_eff),
    .pos_o(fb_pre)
  );
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_pre_reg <= '0;
      fb_post_reg <= '0;
    end else if (drive_rst) begin
      cmd_pre_reg <= '0;
      fb_post_reg <= '0;
    end else begin
      if (cmd_step_i) cmd_pre_reg <= cmd_dir_i ? cmd_pre_reg + 32'sd1 : cmd_pre_reg - 32'sd1;
      if (enc_step) fb_post_reg <= enc_fwd ? fb_post_reg + 32'sd1 : fb_post_reg - 32'sd1;
    end
  end

  // ------------------------------------------------------------
  // droop, fault and position flags
  // ------------------------------------------------------------
  wire signed [31:0] droop = cmd_post - fb_post_reg; // R13
  wire [31:0] droop_abs = droop[31] ? 32'(-droop) : 32'(droop); // R26
  wire inpos = droop_abs <= 32'(inpos_reg); // R12
  wire fault_set = devlim_reg != `PPM_DEV_OFF && droop_abs >= 32'(devlim_reg); // R14 R15 R26
  wire signed [31:0] remain = target_pos_i - cmd_pre_reg;
  wire [31:0] remain_abs = remain[31] ? 32'(-remain) : 32'(remain);
  wire rough = remain_abs <= 32'(rough_reg); // R23
  wire signed [31:0] det_thr = 32'(dethi_reg) * 32'(`PPM_DET_SCALE) + 32'(detlo_reg); // R22
  wire signed [31:0] hyst = 32'(hyst_reg);
  logic plus_on_reg;
  logic minus_on_reg;
  // hysteresis sits below the plus threshold and above the minus one
  wire plus_next = plus_on_reg ? (fb_pre > det_thr - hyst) : (fb_pre > det_thr); // R21 R22
  wire minus_next = minus_on_reg ? (fb_pre < -det_thr + hyst) : (fb_pre < -det_thr); // R21
  wire detect = (side_reg != PPM_SIDE_MINUS && plus_on_reg) ||
                (side_reg != PPM_SIDE_PLUS && minus_on_reg); // R20
  logic [5:0] flags_reg;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      plus_on_reg <= 1'b0;
      minus_on_reg <= 1'b0;
      flags_reg <= '0;
      excessive_deviation_fault_o <= 1'b0;
    end else begin
      plus_on_reg <= plus_next;
      minus_on_reg <= minus_next;
      flags_reg[`PPM_ST_INPOS] <= inpos;
      flags_reg[`PPM_ST_BUSY] <= pos_cmd_busy_i; // R16
      flags_reg[`PPM_ST_TRAVEL] <= inpos & ~pos_cmd_busy_i; // R24
      flags_reg[`PPM_ST_ROUGH] <= rough;
      flags_reg[`PPM_ST_DETECT] <= detect;
      flags_reg[`PPM_ST_FAULT] <= excessive_deviation_fault_o;
      // sticky until drive reset; a new trip in that cycle wins
      if (fault_set) begin
        excessive_deviation_fault_o <= 1'b1; // R14
      end else if (drive_rst) begin
        excessive_deviation_fault_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // output terminals
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    wire hit = wr_en_i && addr_i == 8'(`PPM_OFS_OUTFUNC + 4 * i);
    wire [7:0] fn = out_func_reg[i];
    wire val = fn == `PPM_FN_INPOS ? flags_reg[`PPM_ST_INPOS] : // R17
               fn == `PPM_FN_INPOS_N ? ~flags_reg[`PPM_ST_INPOS] :
               fn == `PPM_FN_BUSY ? flags_reg[`PPM_ST_BUSY] : // R16
               fn == `PPM_FN_BUSY_N ? ~flags_reg[`PPM_ST_BUSY] :
               fn == `PPM_FN_TRAVEL ? flags_reg[`PPM_ST_TRAVEL] :
               fn == `PPM_FN_TRAVEL_N ? ~flags_reg[`PPM_ST_TRAVEL] :
               fn == `PPM_FN_ROUGH ? flags_reg[`PPM_ST_ROUGH] :
               fn == `PPM_FN_ROUGH_N ? ~flags_reg[`PPM_ST_ROUGH] :
               fn == `PPM_FN_DETECT ? flags_reg[`PPM_ST_DETECT] :
               fn == `PPM_FN_DETECT_N ? ~flags_reg[`PPM_ST_DETECT] : 1'b0;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        out_func_reg[i] <= '0;
        term_out_o[i] <= 1'b0;
      end else begin
        if (hit) out_func_reg[i] <= wr_data_i[7:0];
        term_out_o[i] <= val;
      end
    end
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (addr_i == `PPM_OFS_CTRL) begin
      rd_mux = {30'h0, store_reg, clr_mode_reg};
    end else if (addr_i == `PPM_OFS_DIV) begin
      rd_mux = 32'(div_reg);
    end else if (addr_i == `PPM_OFS_GNUM) begin
      rd_mux = 32'(gnum_reg);
    end else if (addr_i == `PPM_OFS_GDEN) begin
      rd_mux = 32'(gden_reg);
    end else if (addr_i == `PPM_OFS_INPOS) begin
      rd_mux = 32'(inpos_reg);
    end else if (addr_i == `PPM_OFS_DEVLIM) begin
      rd_mux = 32'(devlim_reg);
    end else if (addr_i == `PPM_OFS_ROUGH) begin
      rd_mux = 32'(rough_reg);
    end else if (addr_i == `PPM_OFS_DETLO) begin
      rd_mux = 32'(detlo_reg);
    end else if (addr_i == `PPM_OFS_DETHI) begin
      rd_mux = 32'(dethi_reg);
    end else if (addr_i == `PPM_OFS_DETSIDE) begin
      rd_mux = 32'(side_reg);
    end else if (addr_i == `PPM_OFS_DETHYS) begin
      rd_mux = 32'(hyst_reg);
    end else if (addr_i == `PPM_OFS_CUMMON) begin
      rd_mux = 32'(mon_reg);
    end else if (addr_i == `PPM_OFS_CUMOVF) begin
      rd_mux = 32'(ovf_reg);
    end else if (addr_i == `PPM_OFS_CUMCNT) begin
      rd_mux = cum_cnt;
    end else if (addr_i == `PPM_OFS_STATUS) begin
      rd_mux = 32'(flags_reg);
    end else if (addr_i == `PPM_OFS_DROOP) begin
      rd_mux = droop;
    end
    for (int i = 0; i < NUM_IN; i++) begin
      if (addr_i == 8'(`PPM_OFS_INFUNC + 4 * i)) rd_mux = 32'(in_func_reg[i]);
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      if (addr_i == 8'(`PPM_OFS_OUTFUNC + 4 * i)) rd_mux = 32'(out_func_reg[i]);
    end
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_en_i ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// File: testbench/ppm_top_assertions.sv
// port-level checker for the position pulse monitor
`timescale 1ns/100ps
module ppm_top_assertions (
  input wire logic core_clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic [7:0] addr_i, // address
  input wire logic rd_en_i, // read strobe
  input wire logic [31:0] rd_data_o, // read data
  input wire logic excessive_deviation_fault_o, // fault
  input wire logic drive_reset_i, // drive reset
  input wire logic enc_option_i, // option fitted
  input wire logic nv_save_o, // save pulse
  input wire logic [15:0] nv_mon_o // saved monitor
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------
  // properties
  // ----------
  sequence s_rd(a);
    rd_en_i && addr_i == a;
  endsequence
  // option sync needs a few cycles before it is trusted
  sequence s_no_opt;
    !enc_option_i [*4];
  endsequence
  property p_idle;
    !rd_en_i |=> rd_data_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not zero outside a read");
  property p_gnum;
    s_rd(8'h08) |=> rd_data_o[31:15] == 17'h0 && rd_data_o[14:0] != 15'h0;
  endproperty
  a_gnum: assert property (p_gnum) else $error("gear numerator out of range");
  property p_gden;
    s_rd(8'h0c) |=> rd_data_o[31:15] == 17'h0 && rd_data_o[14:0] != 15'h0;
  endproperty
  a_gden: assert property (p_gden) else $error("gear denominator out of range");
  property p_inpos;
    s_rd(8'h10) |=> rd_data_o[31:15] == 17'h0;
  endproperty
  a_inpos: assert property (p_inpos) else $error("in-position width too wide");
  property p_devlim;
    s_rd(8'h14) |=> rd_data_o[31:19] == 13'h0;
  endproperty
  a_devlim: assert property (p_devlim) else $error("deviation limit too wide");
  property p_travel;
    s_rd(8'h6c) |=> rd_data_o[2] == (rd_data_o[0] && !rd_data_o[1]) && rd_data_o[31:6] == 26'h0;
  endproperty
  a_travel: assert property (p_travel) else $error("travel flag inconsistent");
  property p_sticky;
    (excessive_deviation_fault_o && !drive_reset_i) [*4] |=> excessive_deviation_fault_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault dropped without reset");
  property p_pulse;
    nv_save_o |=> !nv_save_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("save pulse too long");
  property p_hold;
    !nv_save_o |-> $stable(nv_mon_o);
  endproperty
  a_hold: assert property (p_hold) else $error("saved data moved without save");
  property p_no_opt;
    s_no_opt |=> !nv_save_o;
  endproperty
  a_no_opt: assert property (p_no_opt) else $error("save without option");
  property p_no_rst;
    drive_reset_i [*4] |=> !nv_save_o;
  endproperty
  a_no_rst: assert property (p_no_rst) else $error("save during drive reset");
endmodule
bind ppm_top ppm_top_assertions i_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .drive_reset_i(drive_reset_i),
  .excessive_deviation_fault_o(excessive_deviation_fault_o), .enc_option_i(enc_option_i),
  .nv_save_o(nv_save_o), .nv_mon_o(nv_mon_o));

// File: testbench/ppm_drive_model.sv
// encoder and command pulse source facing the pulse monitor
`timescale 1ns/100ps
module ppm_drive_model (
  input wire logic core_clk_i, // clock
  output logic enc_a_o, // phase a
  output logic enc_b_o, // phase b
  output logic step_o, // command pulse
  output logic dir_o // 1 forward
);
  initial {enc_a_o, enc_b_o, step_o, dir_o} = 4'h1;
  // ---------
  // traffic
  // ---------
  // four cycles apart so the sync never sees both phases move
  task automatic fwd(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk_i);
      if (enc_a_o == enc_b_o) enc_b_o <= ~enc_b_o;
      else enc_a_o <= ~enc_a_o;
    end
  endtask
  task automatic cmd(input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk_i);
      step_o <= 1'b1;
      @(posedge core_clk_i);
      step_o <= 1'b0;
    end
  endtask
endmodule

// File: testbench/test_position_pulse_monitor.sv
// self-checking bench for the position pulse monitor
`timescale 1ns/100ps
module test_position_pulse_monitor;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] tin = 2'h0;
  logic drst = 1'b0;
  logic pfail = 1'b0;
  logic opt = 1'b0;
  logic [31:0] rdata, tgt = 32'h0;
  logic busy = 1'b0, pup = 1'b0;
  logic [3:0] tout;
  logic fault, save, ea, eb, stp, dir;
  logic [15:0] nvm, nvi = 16'h0;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] ra [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h7c};
  logic [31:0] rv [9] = '{32'h1, 32'h1, 32'h1, 32'h64, 32'h9c40, 32'h0, 32'h0, 32'h0, 32'h0};
  always #20 core_clk_i = ~core_clk_i;
  ppm_top i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdata), .enc_a_i(ea), .enc_b_i(eb), .term_in_i(tin),
    .cmd_step_i(stp), .cmd_dir_i(dir), .target_pos_i(tgt), .pos_cmd_busy_i(busy),
    .drive_reset_i(drst), .power_fail_i(pfail), .power_up_i(pup), .enc_option_i(opt),
    .nv_mon_i(nvi), .nv_ovf_i(nvi), .term_out_o(tout), .excessive_deviation_fault_o(fault),
    .nv_save_o(save), .nv_mon_o(nvm), .nv_ovf_o());
  ppm_drive_model i_drv (.core_clk_i(core_clk_i), .enc_a_o(ea), .enc_b_o(eb), .step_o(stp),
    .dir_o(dir));
  // -----
  // tasks
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    {addr, rd} <= {a, 1'b1};
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pulse_in(input logic [1:0] v);
    tin <= v;
    idle(6);
    tin <= 2'h0;
    idle(6);
  endtask
  task automatic dreset;
    drst <= 1'b1;
    idle(6);
    drst <= 1'b0;
    idle(6);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // -----
  // tests
  // -----
  initial begin
    idle(3);
    arst_n_i <= 1'b1;
    foreach (ra[i]) rreg(ra[i], rv[i]);
    $display("reset values done");
    wreg(8'h04, 32'h3);
    wreg(8'h40, 32'h24);
    i_drv.fwd(10);
    idle(8);
    rreg(8'h60, 32'ha);
    rreg(8'h64, 32'h0);
    rreg(8'h68, 32'h1e);
    rreg(8'h70, 32'hfffffff6);
    rreg(8'h6c, 32'h1d);
    chk({28'h0, tout}, 32'h1);
    {busy, tgt} <= {1'b1, 32'h5};
    rreg(8'h6c, 32'h13);
    $display("counting done");
    pulse_in(2'h2);
    rreg(8'h60, 32'ha);
    wreg(8'h2c, 32'h34);
    pulse_in(2'h1);
    rreg(8'h60, 32'h0);
    $display("edge clear done");
    wreg(8'h00, 32'h1);
    tin <= 2'h1;
    i_drv.fwd(3);
    idle(6);
    rreg(8'h60, 32'h0);
    tin <= 2'h0;
    i_drv.fwd(2);
    idle(8);
    rreg(8'h60, 32'h2);
    $display("level clear done");
    dreset();
    rreg(8'h60, 32'h0);
    wreg(8'h14, 32'h5);
    i_drv.cmd(4);
    idle(8);
    chk({31'h0, fault}, 32'h0);
    i_drv.cmd(1);
    idle(8);
    chk({31'h0, fault}, 32'h1);
    wreg(8'h14, 32'h270f);
    dreset();
    i_drv.cmd(10000);
    idle(8);
    chk({31'h0, fault}, 32'h0);
    $display("deviation done");
    dreset();
    wreg(8'h00, 32'h2);
    opt <= 1'b1;
    i_drv.fwd(4);
    idle(8);
    pfail <= 1'b1;
    repeat (10) if (save !== 1'b1) @(posedge core_clk_i) #1;
    chk({15'h0, save, nvm}, 32'h00010004);
    {pfail, drst} <= 2'b01;
    idle(4);
    pfail <= 1'b1;
    dreset();
    rreg(8'h60, 32'h4);
    {nvi, pup} <= {16'h7, 1'b1};
    idle(4);
    rreg(8'h60, 32'h7);
    $display("storage done");
    finish_test();
  end
  // about 40300 cycles of tests, cut off with margin
  initial begin
    #2400000;
    mismatches++;
    finish_test();
  end
endmodule
